// *** hdl/amx_pkg.sv ***
// Operation
// - a falling trigger edge raises the busy status output
// - busy stays high for the whole conversion
// - busy falls at conversion end; the new result is then readable
// - channel selection changes only on a rising channel-advance edge, or on busy rising instead when the CTRL tie bit is set
// - scan-mode input high selects automatic scan
// - in automatic scan the select pair gives the last channel; start is 0
// - automatic: advance edge with sequence reset low selects next channel
// - automatic: advance from the last channel wraps to channel 0
// - automatic: advance edge with sequence reset high forces channel 0
// - automatic: select pair is binary last channel, 00 to 11
// - scan-mode input low selects manual addressing
// - manual: each advance edge connects the addressed channel
// - manual: select pair addresses channels 0-3; sequence reset ignored
package amx_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] AMX_OFS_CTRL     = 8'h00;
	localparam logic [7:0] AMX_OFS_STATUS   = 8'h04;
	localparam logic [7:0] AMX_OFS_RESULT   = 8'h08;
	localparam logic [7:0] AMX_OFS_INT_STAT = 8'h0c;
	localparam logic [7:0] AMX_OFS_INT_MASK = 8'h10;

	localparam int AMX_CTRL_TIE_BIT  = 0;
	localparam int AMX_INT_DONE_BIT  = 0;
	localparam int AMX_INT_CHAN_BIT  = 1;
	localparam int AMX_INT_W         = 2;

	localparam logic       AMX_CTRL_RST     = 1'h0;
	localparam logic [1:0] AMX_INT_MASK_RST = 2'h0;
	localparam logic [1:0] AMX_CHAN_RST     = 2'h0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int AMX_CLK_PERIOD_NS = 5;
	localparam int AMX_CONV_TIME_NS  = 650;
	localparam int AMX_CONV_CYC      =
		(AMX_CONV_TIME_NS + AMX_CLK_PERIOD_NS - 1) / AMX_CLK_PERIOD_NS;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic convTrigger;
		logic chanAdvClk;
		logic scanMode;
		logic chanSelHigh;
		logic chanSelLow;
		logic seqResetSel;
		logic csN;
		logic rdN;
	} amx_pins_t;

	typedef enum logic {AMX_IDLE, AMX_CONVERTING} amx_conv_t;

endpackage : amx_pkg

// *** hdl/amx_sequencer.sv ***
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module amx_sequencer
	import amx_pkg::*;
#(
	parameter int DATA_W = 18
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire amx_pins_t         pins,
	input  wire logic [DATA_W-1:0] sampleData,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   busy,
	output logic [1:0]             chanSel,
	output logic [DATA_W-1:0]      dataOut,
	output logic                   dataOe,
	output logic                   irq
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	amx_pins_t pinMeta_r;
	amx_pins_t pinSync_r;
	logic      trigPrev_r;
	logic      advPrev_r;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pinMeta_r <= '1;
			pinSync_r <= '1;
		end else begin
			pinMeta_r <= pins;
			pinSync_r <= pinMeta_r;
		end
	end

	// ----------------------------------------
	// registers and apb
	// ----------------------------------------
	logic                  tieAdv_r;
	logic [AMX_INT_W-1:0]  intStat_r;
	logic [AMX_INT_W-1:0]  intMask_r;
	logic [DATA_W-1:0]     result_r;
	logic [DATA_W-1:0]     sampleHold_r;
	amx_conv_t             convState_r;
	logic [7:0]            convCnt_r;
	logic                  apbAccess;
	logic                  apbCommit;
	logic                  addrOk;
	logic [31:0]           rdMux;

	assign apbAccess = psel & penable;
	assign apbCommit = apbAccess & pready;

	always_comb begin
		addrOk = 1'b1;
		rdMux  = 32'h0;
		unique case (paddr)
			AMX_OFS_CTRL:     rdMux[0] = tieAdv_r;
			AMX_OFS_STATUS:   rdMux = {28'h0, pinSync_r.scanMode,
				chanSel, busy};
			AMX_OFS_RESULT:   rdMux[DATA_W-1:0] = result_r;
			AMX_OFS_INT_STAT: rdMux[AMX_INT_W-1:0] = intStat_r;
			AMX_OFS_INT_MASK: rdMux[AMX_INT_W-1:0] = intMask_r;
			default:          addrOk = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (apbAccess && !pready) begin
			pready  <= 1'b1;
			pslverr <= ~addrOk;
			prdata  <= pwrite ? 32'h0 : rdMux;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tieAdv_r  <= AMX_CTRL_RST;
			intMask_r <= AMX_INT_MASK_RST;
		end else if (apbCommit && pwrite) begin
			if (paddr == AMX_OFS_CTRL)
				tieAdv_r <= pwdata[AMX_CTRL_TIE_BIT];
			if (paddr == AMX_OFS_INT_MASK)
				intMask_r <= pwdata[AMX_INT_W-1:0];
		end
	end

	// ----------------------------------------
	// conversion control
	// ----------------------------------------
	logic trigFall;
	logic convEnd;

	assign trigFall = trigPrev_r & ~pinSync_r.convTrigger;
	assign convEnd  = (convState_r == AMX_CONVERTING) && (convCnt_r == 8'h0);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			trigPrev_r   <= 1'b1;
			convState_r  <= AMX_IDLE;
			convCnt_r    <= 8'h0;
			busy         <= 1'b0;
			sampleHold_r <= '0;
		end else begin
			trigPrev_r <= pinSync_r.convTrigger;
			unique case (convState_r)
				AMX_IDLE: begin
					if (trigFall) begin
						convState_r  <= AMX_CONVERTING;
						busy         <= 1'b1;
						convCnt_r    <= 8'(AMX_CONV_CYC - 1);
						sampleHold_r <= sampleData;
					end
				end
				AMX_CONVERTING: begin
					if (convEnd) begin
						convState_r <= AMX_IDLE;
						busy        <= 1'b0;
					end else begin
						convCnt_r <= convCnt_r - 8'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			result_r <= '0;
		else if (convEnd)
			result_r <= sampleHold_r;
	end

	// ----------------------------------------
	// multiplexer sequencing
	// ----------------------------------------
	logic       advSrc;
	logic       advRise;
	logic [1:0] selPair;
	logic [1:0] chanNxt;

	assign advSrc  = tieAdv_r ? busy : pinSync_r.chanAdvClk;
	assign advRise = advSrc & ~advPrev_r;
	assign selPair = {pinSync_r.chanSelHigh, pinSync_r.chanSelLow};

	always_comb begin
		if (!pinSync_r.scanMode)
			chanNxt = selPair;
		else if (pinSync_r.seqResetSel)
			chanNxt = 2'h0;
		else if (chanSel >= selPair)
			chanNxt = 2'h0;
		else
			chanNxt = chanSel + 2'h1;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			advPrev_r <= 1'b1;
			chanSel   <= AMX_CHAN_RST;
		end else begin
			advPrev_r <= advSrc;
			if (advRise)
				chanSel <= chanNxt;
		end
	end

	// ----------------------------------------
	// parallel data bus
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dataOe  <= 1'b0;
			dataOut <= '0;
		end else begin
			dataOe  <= ~pinSync_r.csN & ~pinSync_r.rdN;
			dataOut <= result_r;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	logic [AMX_INT_W-1:0] intSet;
	logic [AMX_INT_W-1:0] intClr;

	assign intSet = {advRise, convEnd};
	assign intClr = (apbCommit && pwrite && paddr == AMX_OFS_INT_STAT)
		? pwdata[AMX_INT_W-1:0] : '0;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			intStat_r <= '0;
			irq       <= 1'b0;
		end else begin
			intStat_r <= (intStat_r & ~intClr) | intSet;
			irq       <= |(((intStat_r & ~intClr) | intSet) & intMask_r);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_trig_fall;
		trigFall && convState_r == AMX_IDLE;
	endsequence

	sequence s_conv_run;
		busy [*8];
	endsequence

	a_busy_rise: assert property (@(posedge mclk) disable iff (sys_rst)
		s_trig_fall |=> busy)
		else $error("busy did not rise after trigger fall");

	a_busy_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		s_trig_fall |=> s_conv_run)
		else $error("busy dropped early");

	a_busy_len: assert property (@(posedge mclk) disable iff (sys_rst)
		s_trig_fall |-> ##130 busy ##1 !busy)
		else $error("conversion length wrong");

	a_result_load: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(busy) |-> result_r == $past(sampleHold_r))
		else $error("result not loaded at busy fall");

	a_chan_stable: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(advRise) |-> $stable(chanSel))
		else $error("channel changed without advance edge");

	a_auto_step: assert property (@(posedge mclk) disable iff (sys_rst)
		advRise && pinSync_r.scanMode && !pinSync_r.seqResetSel
		&& chanSel < selPair |=> chanSel == $past(chanSel) + 2'h1)
		else $error("auto scan did not step");

	a_auto_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
		advRise && pinSync_r.scanMode && chanSel == selPair
		|=> chanSel == 2'h0)
		else $error("auto scan did not wrap");

	a_auto_reset: assert property (@(posedge mclk) disable iff (sys_rst)
		advRise && pinSync_r.scanMode && pinSync_r.seqResetSel
		|=> chanSel == 2'h0)
		else $error("sequence reset ignored");

	a_manual_addr: assert property (@(posedge mclk) disable iff (sys_rst)
		advRise && !pinSync_r.scanMode |=> chanSel == $past(selPair))
		else $error("manual address not taken");

	a_bus_drive: assert property (@(posedge mclk) disable iff (sys_rst)
		dataOe |-> !$past(pinSync_r.csN) && !$past(pinSync_r.rdN))
		else $error("data bus driven without strobes");

	a_busy_state: assert property (@(posedge mclk) disable iff (sys_rst)
		busy == (convState_r == AMX_CONVERTING))
		else $error("busy does not match conversion state");

	a_busy_stay: assert property (@(posedge mclk) disable iff (sys_rst)
		busy && !convEnd |=> busy)
		else $error("busy fell before conversion end");

	a_busy_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
		trigFall && convState_r == AMX_CONVERTING && !convEnd
		|=> busy && convCnt_r == $past(convCnt_r) - 8'h1)
		else $error("trigger during conversion was taken");

	a_conv_count: assert property (@(posedge mclk) disable iff (sys_rst)
		s_trig_fall |=> convCnt_r == 8'(AMX_CONV_CYC - 1))
		else $error("conversion counter not loaded");

	a_idle_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		convState_r == AMX_IDLE && !trigFall |=> !busy)
		else $error("busy rose without trigger fall");

	a_busy_end: assert property (@(posedge mclk) disable iff (sys_rst)
		convEnd |=> !busy)
		else $error("busy stayed high after conversion end");

	a_result_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!convEnd |=> $stable(result_r))
		else $error("result changed outside conversion end");

	a_data_follow: assert property (@(posedge mclk) disable iff (sys_rst)
		dataOe |-> dataOut == $past(result_r))
		else $error("bus data is not the last result");

	a_bus_release: assert property (@(posedge mclk) disable iff (sys_rst)
		!dataOe |-> $past(pinSync_r.csN) || $past(pinSync_r.rdN))
		else $error("data bus released while strobes low");

	a_manual_ignore: assert property (@(posedge mclk) disable iff (sys_rst)
		advRise && !pinSync_r.scanMode && pinSync_r.seqResetSel
		|=> chanSel == $past(selPair))
		else $error("manual mode obeyed sequence reset");

	a_auto_single: assert property (@(posedge mclk) disable iff (sys_rst)
		advRise && pinSync_r.scanMode && selPair == 2'h0
		|=> chanSel == 2'h0)
		else $error("single channel scan left channel 0");

	a_auto_range: assert property (@(posedge mclk) disable iff (sys_rst)
		advRise && pinSync_r.scanMode |=> chanSel <= $past(selPair))
		else $error("auto scan passed the last channel");

	a_ready_set: assert property (@(posedge mclk) disable iff (sys_rst)
		apbAccess && !pready |=> pready)
		else $error("access phase not answered");

	a_ready_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
		pready |=> !pready)
		else $error("ready stood longer than one cycle");

	a_err_unmapped: assert property (@(posedge mclk) disable iff (sys_rst)
		apbAccess && !pready && !addrOk |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");

	a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
		irq == |(intStat_r & $past(intMask_r)))
		else $error("interrupt level does not match status");

	a_set_wins: assert property (@(posedge mclk) disable iff (sys_rst)
		intSet != '0 |=> (intStat_r & $past(intSet)) == $past(intSet))
		else $error("event did not set its status bit");

	a_clear_one: assert property (@(posedge mclk) disable iff (sys_rst)
		(intClr & ~intSet) != '0 |=> (intStat_r & $past(intClr & ~intSet)) == '0)
		else $error("write one did not clear status");

endmodule : amx_sequencer

`default_nettype wire

// *** sim/adc_conversion_and_mux_sequencer_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_and_mux_sequencer_test;
	import amx_pkg::*;
	logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rnd = 32'hb193fd3e;
	logic [17:0] sampleData = '0, dataOut;
	logic        pready, pslverr, busy, dataOe, irq;
	logic [1:0]  chanSel;
	amx_pins_t   pins;
	int          badCount = 0, nCompared = 0, cyc = 0, hiCnt = 0;
	logic [32:0] rdQ[$];
	logic [1:0]  chQ[$];
	logic [5:0]  tbl[17] = '{6'h16, 6'h1b, 6'h0d, 6'h00, 6'h31, 6'h32,
		6'h30, 6'h31, 6'h3c, 6'h39, 6'h3a, 6'h3b, 6'h38, 6'h29, 6'h20,
		6'h29, 6'h28};
	always #2.5 mclk = ~mclk;
	amx_host_model host (.mclk, .pins);
	amx_sequencer uut (.mclk, .sys_rst, .pins, .sampleData, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.busy, .chanSel, .dataOut, .dataOe, .irq);
	// ------
	// checking
	// ------
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		nCompared++;
		if (g !== e) begin
			badCount++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	task automatic test_done();
		$display("compared %0d errors %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk({pslverr, prdata}, rdQ.pop_front());
		if (busy === 1'b1)
			hiCnt <= hiCnt + 1;
		else if (hiCnt != 0) begin
			chk(33'(hiCnt), 33'(AMX_CONV_CYC));
			hiCnt <= 0;
		end
		if (++cyc == 5000) begin
			badCount++;
			test_done();
		end
	end
	always @(chanSel)
		if (!sys_rst)
			chk(33'(chanSel), 33'(chQ.pop_front()));
	// ------
	// bus master
	// ------
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge mclk) penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rdQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// ------
	// scenarios
	// ------
	initial begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(AMX_OFS_CTRL, 33'h0);
		rd(AMX_OFS_INT_MASK, 33'h0);
		rd(8'h14, 33'h100000000);
		foreach (tbl[i]) begin
			chQ.push_back(tbl[i][1:0]);
			host.adv(tbl[i][5:2]);
		end
		chk(33'(irq), 33'h0);
		rd(AMX_OFS_STATUS, 33'h8);
		rd(AMX_OFS_INT_STAT, 33'h2);
		apb(1'b1, AMX_OFS_INT_MASK, 32'h3);
		apb(1'b1, AMX_OFS_CTRL, 32'h1);
		chk(33'(irq), 33'h1);
		rnd = xs(rnd);
		sampleData <= rnd[17:0];
		chQ.push_back(2'h1);
		host.conv();
		chk(33'(busy), 33'h1);
		host.conv();
		while (busy !== 1'b0) @(posedge mclk);
		rd(AMX_OFS_RESULT, 33'(rnd[17:0]));
		rd(AMX_OFS_INT_STAT, 33'h3);
		apb(1'b1, AMX_OFS_INT_STAT, 32'h3);
		rd(AMX_OFS_INT_STAT, 33'h0);
		chk(33'(irq), 33'h0);
		host.bus(1'b0);
		chk(33'(dataOe), 33'h1);
		chk(33'(dataOut), 33'(rnd[17:0]));
		host.bus(1'b1);
		chk(33'(dataOe), 33'h0);
		test_done();
	end
endmodule : adc_conversion_and_mux_sequencer_test
`default_nettype wire

// *** sim/amx_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------
// host pin driver
// ------
module amx_host_model
	import amx_pkg::*;
(
	input  wire logic     mclk,
	output var amx_pins_t pins
);
	initial pins = 8'h83;
	task automatic conv();
		@(posedge mclk) pins.convTrigger <= 1'b0;
		repeat (4) @(posedge mclk);
		pins.convTrigger <= 1'b1;
	endtask : conv
	// levels settle first, then a clean rising advance edge
	task automatic adv(input logic [3:0] v);
		@(posedge mclk) {pins.scanMode, pins.chanSelHigh,
			pins.chanSelLow, pins.seqResetSel} <= v;
		repeat (3) @(posedge mclk);
		pins.chanAdvClk <= 1'b1;
		repeat (5) @(posedge mclk);
		pins.chanAdvClk <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : adv
	task automatic bus(input logic l);
		@(posedge mclk) {pins.csN, pins.rdN} <= {l, l};
		repeat (5) @(posedge mclk);
	endtask : bus
endmodule : amx_host_model
`default_nettype wire
